// [word_range_engine.v]
// word range engine: compare-search, byte exchange, maximum and minimum search over memory
// assumes an avalon-mm master on the same clock and a word memory that acks each access
`timescale 1ns/1ps
`include "range_engine_defines.vh"

module word_range_engine
(
  input  wire        mclk,
  input  wire        rst_n,
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  output reg  [15:0] mem_addr,
  output reg         mem_rd,
  output reg         mem_wr,
  output reg  [15:0] mem_wdata,
  input  wire [15:0] mem_rdata,
  input  wire        mem_ack,
  output wire        irq
);

  localparam S_IDLE = 3'd0;
  localparam S_RD   = 3'd1;
  localparam S_EVAL = 3'd2;
  localparam S_WR   = 3'd3;
  localparam S_NEXT = 3'd4;
  localparam S_FIN  = 3'd5;

  reg [2:0]  state_r;
  reg [1:0]  op_r;
  reg [15:0] len_r;
  reg [15:0] opt_r;
  reg [15:0] first_range_word_r;
  reg [15:0] compare_value_r;
  reg [15:0] dest_r;
  reg [15:0] index_reg_zero_r;
  reg [15:0] data_reg_zero_r;
  reg [1:0]  irq_mask_r;
  reg        fault_flag_r;
  reg        match_flag_r;
  reg        neg_flag_r;
  reg [15:0] result_r;

  reg [15:0] ptr_r;
  reg [15:0] remain_r;
  reg [15:0] word_r;
  reg [15:0] best_r;
  reg [15:0] best_addr_r;
  reg        have_best_r;
  reg        hit_r;
  reg [15:0] hit_addr_r;
  reg [15:0] hit_cnt_r;
  reg        dest_phase_r;
  reg        done_ev_r;
  reg        fault_ev_r;

  wire       bus_take;
  wire       bus_wr;
  wire       start_req;
  wire       stat_read;
  wire       better;
  wire [1:0] irq_status;
  wire       busy;

  // the request is taken on the edge where waitrequest was already low
  assign bus_take  = (avs_read | avs_write) & ~avs_waitrequest;
  assign bus_wr    = avs_write & ~avs_waitrequest;
  assign stat_read = avs_read & ~avs_waitrequest & (avs_address == `REG_IRQ_STAT);
  assign start_req = bus_wr & (avs_address == `REG_CTRL) & avs_writedata[`CTRL_START_BIT];
  assign busy      = (state_r != S_IDLE);

  extreme_cmp u_cmp
  (
    .cand        (word_r),
    .best        (best_r),
    .signed_mode (opt_r[`OPT_SIGNED_BIT]),
    .find_max    (op_r == `OP_MAX),
    .better      (better)
  );

  irq_sticky #(.N(`IRQ_COUNT)) u_irq
  (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .event_in   ({fault_ev_r, done_ev_r}),
    .read_clear (stat_read),
    .mask       (irq_mask_r),
    .status     (irq_status),
    .irq        (irq)
  );

  // avalon slave: one wait cycle, then a single cycle with waitrequest low
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end
    else if (bus_take)
    begin
      avs_waitrequest <= 1'b1;
    end
    else if ((avs_read | avs_write) & avs_waitrequest)
    begin
      avs_waitrequest <= 1'b0;
      case (avs_address)
        `REG_CTRL:     avs_readdata <= {30'h0000_0000, op_r};
        `REG_LEN:      avs_readdata <= {16'h0000, len_r};
        `REG_OPT:      avs_readdata <= {16'h0000, opt_r};
        `REG_FIRST:    avs_readdata <= {16'h0000, first_range_word_r};
        `REG_CMPV:     avs_readdata <= {16'h0000, compare_value_r};
        `REG_DEST:     avs_readdata <= {16'h0000, dest_r};
        `REG_STATUS:   avs_readdata <= {28'h000_0000, neg_flag_r, match_flag_r, fault_flag_r, busy};
        `REG_INDEX:    avs_readdata <= {16'h0000, index_reg_zero_r};
        `REG_DATA0:    avs_readdata <= {16'h0000, data_reg_zero_r};
        `REG_IRQ_STAT: avs_readdata <= {30'h0000_0000, irq_status};
        `REG_IRQ_MASK: avs_readdata <= {30'h0000_0000, irq_mask_r};
        `REG_RESULT:   avs_readdata <= {16'h0000, result_r};
        default:       avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // operand registers; operand writes while busy are ignored so a running scan keeps its operands, but the irq mask is written at any time
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      op_r               <= `OP_SEARCH;
      len_r              <= `LEN_RESET;
      opt_r              <= `OPT_RESET;
      first_range_word_r <= `WORD_ZERO;
      compare_value_r    <= `WORD_ZERO;
      dest_r             <= `WORD_ZERO;
      irq_mask_r         <= 2'h0;
    end
    else if (bus_wr)
    begin
      if (avs_address == `REG_IRQ_MASK)
        irq_mask_r <= avs_writedata[1:0];
      if (!busy)
      begin
        case (avs_address)
          `REG_CTRL:  op_r               <= avs_writedata[`CTRL_OP_MSB:`CTRL_OP_LSB];
          `REG_LEN:   len_r              <= avs_writedata[15:0];
          `REG_OPT:   opt_r              <= avs_writedata[15:0];
          `REG_FIRST: first_range_word_r <= avs_writedata[15:0];
          `REG_CMPV:  compare_value_r    <= avs_writedata[15:0];
          `REG_DEST:  dest_r             <= avs_writedata[15:0];
          default:    op_r               <= op_r;
        endcase
      end
    end
  end

  // sequencer and result registers
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r          <= S_IDLE;
      ptr_r            <= `WORD_ZERO;
      remain_r         <= `WORD_ZERO;
      word_r           <= `WORD_ZERO;
      best_r           <= `WORD_ZERO;
      best_addr_r      <= `WORD_ZERO;
      have_best_r      <= 1'b0;
      hit_r            <= 1'b0;
      hit_addr_r       <= `WORD_ZERO;
      hit_cnt_r        <= `WORD_ZERO;
      dest_phase_r     <= 1'b0;
      fault_flag_r     <= 1'b0;
      match_flag_r     <= 1'b0;
      neg_flag_r       <= 1'b0;
      result_r         <= `WORD_ZERO;
      index_reg_zero_r <= `WORD_ZERO;
      data_reg_zero_r  <= `WORD_ZERO;
      mem_addr         <= `WORD_ZERO;
      mem_rd           <= 1'b0;
      mem_wr           <= 1'b0;
      mem_wdata        <= `WORD_ZERO;
      done_ev_r        <= 1'b0;
      fault_ev_r       <= 1'b0;
    end
    else
    begin
      done_ev_r  <= 1'b0;
      fault_ev_r <= 1'b0;
      case (state_r)
        S_IDLE:
        begin
          if (bus_wr && avs_address == `REG_INDEX)
            index_reg_zero_r <= avs_writedata[15:0];
          if (bus_wr && avs_address == `REG_DATA0)
            data_reg_zero_r <= avs_writedata[15:0];
          if (start_req)
          begin
            // a zero length is the only value outside the legal range of a 16-bit count
            if (len_r == `WORD_ZERO)
            begin
              fault_flag_r <= 1'b1;
              fault_ev_r   <= 1'b1;
              done_ev_r    <= 1'b1;
            end
            else
            begin
              fault_flag_r <= 1'b0;
              ptr_r        <= first_range_word_r;
              remain_r     <= len_r;
              have_best_r  <= 1'b0;
              hit_r        <= 1'b0;
              hit_cnt_r    <= `WORD_ZERO;
              dest_phase_r <= 1'b0;
              mem_addr     <= first_range_word_r;
              mem_rd       <= 1'b1;
              state_r      <= S_RD;
            end
          end
        end
        S_RD:
        begin
          // the request stands until the memory acks; data is only valid in that cycle
          if (mem_ack)
          begin
            mem_rd  <= 1'b0;
            word_r  <= mem_rdata;
            state_r <= S_EVAL;
          end
        end
        S_EVAL:
        begin
          case (op_r)
            `OP_SEARCH:
            begin
              if (word_r == compare_value_r)
              begin
                // only the first hit keeps its address, later hits just count
                if (!hit_r)
                  hit_addr_r <= ptr_r;
                hit_r     <= 1'b1;
                hit_cnt_r <= hit_cnt_r + `WORD_ONE;
              end
              state_r <= S_NEXT;
            end
            `OP_SWAP:
            begin
              mem_addr  <= ptr_r;
              mem_wdata <= {word_r[7:0], word_r[15:8]};
              mem_wr    <= 1'b1;
              state_r   <= S_WR;
            end
            default:
            begin
              // strict compare in u_cmp keeps the lowest address on ties
              if (!have_best_r || better)
              begin
                best_r      <= word_r;
                best_addr_r <= ptr_r;
                have_best_r <= 1'b1;
              end
              state_r <= S_NEXT;
            end
          endcase
        end
        S_WR:
        begin
          if (mem_ack)
          begin
            mem_wr <= 1'b0;
            if (dest_phase_r)
              state_r <= S_FIN;
            else
              state_r <= S_NEXT;
          end
        end
        S_NEXT:
        begin
          if (remain_r == `WORD_ONE)
          begin
            if ((op_r == `OP_MAX) || (op_r == `OP_MIN))
            begin
              // extreme searches end with a single write of the result word
              mem_addr     <= dest_r;
              mem_wdata    <= best_r;
              mem_wr       <= 1'b1;
              dest_phase_r <= 1'b1;
              state_r      <= S_WR;
            end
            else
              state_r <= S_FIN;
          end
          else
          begin
            remain_r <= remain_r - `WORD_ONE;
            ptr_r    <= ptr_r + `WORD_ONE;
            mem_addr <= ptr_r + `WORD_ONE;
            mem_rd   <= 1'b1;
            state_r  <= S_RD;
          end
        end
        S_FIN:
        begin
          case (op_r)
            `OP_SEARCH:
            begin
              match_flag_r <= hit_r;
              // a miss leaves both result registers as software last saw them
              if (hit_r)
              begin
                index_reg_zero_r <= hit_addr_r;
                if (opt_r[`OPT_COUNT_BIT])
                  data_reg_zero_r <= hit_cnt_r;
              end
            end
            `OP_SWAP:
            begin
              // the exchange reports only through the fault flag, cleared at start
              result_r <= result_r;
            end
            default:
            begin
              result_r     <= best_r;
              match_flag_r <= (best_r == `WORD_ZERO);
              neg_flag_r   <= ((best_r & `SIGN_MASK) != `WORD_ZERO);
              if (opt_r[`OPT_ADDR_BIT])
                index_reg_zero_r <= best_addr_r;
            end
          endcase
          dest_phase_r <= 1'b0;
          done_ev_r    <= 1'b1;
          state_r      <= S_IDLE;
        end
        default:
          state_r <= S_IDLE;
      endcase
    end
  end

endmodule // word_range_engine

// [range_engine_defines.vh]
// register map, control fields, operation codes and reset values of the word range engine
// assumes a 32-bit avalon-mm slave with word addressing and a 16-bit word-addressed data memory
`ifndef RANGE_ENGINE_DEFINES_VH
`define RANGE_ENGINE_DEFINES_VH

// register word offsets on the avalon address bus
`define REG_CTRL        4'h0
`define REG_LEN         4'h1
`define REG_OPT         4'h2
`define REG_FIRST       4'h3
`define REG_CMPV        4'h4
`define REG_DEST        4'h5
`define REG_STATUS      4'h6
`define REG_INDEX       4'h7
`define REG_DATA0       4'h8
`define REG_IRQ_STAT    4'h9
`define REG_IRQ_MASK    4'ha
`define REG_RESULT      4'hb

// control register fields
`define CTRL_OP_LSB     0
`define CTRL_OP_MSB     1
`define CTRL_START_BIT  8

// operation codes
`define OP_SEARCH       2'h0
`define OP_SWAP         2'h1
`define OP_MAX          2'h2
`define OP_MIN          2'h3

// option word fields
`define OPT_SIGNED_BIT  15
`define OPT_COUNT_BIT   15
`define OPT_ADDR_BIT    14

// status register fields
`define STAT_BUSY_BIT   0
`define STAT_FAULT_BIT  1
`define STAT_MATCH_BIT  2
`define STAT_NEG_BIT    3

// interrupt bits
`define IRQ_DONE_BIT    0
`define IRQ_FAULT_BIT   1
`define IRQ_COUNT       2

// reset values and constants
`define LEN_RESET       16'h0000
`define OPT_RESET       16'h0000
`define WORD_ZERO       16'h0000
`define WORD_ONE        16'h0001
`define SIGN_MASK       16'h8000

`endif

// [extreme_cmp.v]
// magnitude comparator for the extreme-value searches
// purely combinational; the caller registers the result
`timescale 1ns/1ps

module extreme_cmp
(
  input  wire [15:0] cand,
  input  wire [15:0] best,
  input  wire        signed_mode,
  input  wire        find_max,
  output wire        better
);

  // flipping the sign bit turns a two's complement order into an unsigned one
  wire [15:0] cand_key;
  wire [15:0] best_key;

  assign cand_key = {cand[15] ^ signed_mode, cand[14:0]};
  assign best_key = {best[15] ^ signed_mode, best[14:0]};
  // strict compare, so an equal later word never displaces the earlier one
  assign better   = find_max ? (cand_key > best_key) : (cand_key < best_key);

endmodule // extreme_cmp

// [irq_sticky.v]
// sticky event bits, cleared by a read, gated by a mask onto one level interrupt
// assumes events and the read-clear strobe come from the same clock domain
`timescale 1ns/1ps

module irq_sticky
#(
  parameter N = 2
)
(
  input  wire         mclk,
  input  wire         rst_n,
  input  wire [N-1:0] event_in,
  input  wire         read_clear,
  input  wire [N-1:0] mask,
  output wire [N-1:0] status,
  output reg          irq
);

  reg [N-1:0] status_r;

  genvar i;
  generate
    for (i = 0; i < N; i = i + 1)
    begin : g_bit
      // an event in the clearing cycle survives the clear
      always @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
          status_r[i] <= 1'b0;
        else if (event_in[i])
          status_r[i] <= 1'b1;
        else if (read_clear)
          status_r[i] <= 1'b0;
      end
    end
  endgenerate

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(status_r & mask);
  end

  assign status = status_r;

endmodule // irq_sticky

// [word_range_engine_checker.sv]
// checker for the word range engine: memory-side order, data and bounds
// assumes register writes reach the engine on the avalon-mm port it watches
`timescale 1ns/1ps
`include "range_engine_defines.vh"
module word_range_engine_checker
(
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [15:0] mem_addr,
  input wire logic        mem_rd,
  input wire logic        mem_wr,
  input wire logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic        mem_ack,
  input wire logic        irq
);
  logic [15:0] len_r, dest_r, last_a_r, last_d_r;
  logic [16:0] nrd_r;
  logic [1:0]  op_r;
  logic        have_r;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // shadow of what software asked for, so each access can be judged against it
  always @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      len_r <= 16'h0000; dest_r <= 16'h0000; last_a_r <= 16'h0000; last_d_r <= 16'h0000;
      nrd_r <= 17'h00000; op_r <= 2'h0; have_r <= 1'b0;
    end
    else if (avs_write && !avs_waitrequest)
    begin
      if (avs_address == `REG_LEN) len_r <= avs_writedata[15:0];
      if (avs_address == `REG_DEST) dest_r <= avs_writedata[15:0];
      if (avs_address == `REG_CTRL)
      begin
        op_r <= avs_writedata[1:0]; have_r <= 1'b0; nrd_r <= 17'h00000;
      end
    end
    else if (mem_rd && mem_ack)
    begin
      last_a_r <= mem_addr; last_d_r <= mem_rdata; have_r <= 1'b1; nrd_r <= nrd_r + 17'h00001;
    end
  chk_no_rdwr: assert property (!(mem_rd && mem_wr)) else $error("memory read and write together");
  chk_rd_held: assert property (mem_rd && !mem_ack |=> mem_rd && $stable(mem_addr))
    else $error("read request dropped before ack");
  chk_ascending: assert property (mem_rd && mem_ack && have_r |-> mem_addr == last_a_r + 16'h0001)
    else $error("range read out of order");
  chk_read_count: assert property (mem_rd && mem_ack |-> nrd_r < {1'b0, len_r})
    else $error("read past end of range");
  chk_swap_data: assert property (mem_wr && op_r == `OP_SWAP |-> mem_addr == last_a_r
    && mem_wdata == {last_d_r[7:0], last_d_r[15:8]}) else $error("swapped word wrong");
  chk_fault_quiet: assert property (mem_wr |-> len_r != 16'h0000) else $error("write on zero length");
  chk_search_ro: assert property (mem_wr |-> op_r != `OP_SEARCH) else $error("search wrote memory");
  chk_dest_only: assert property (mem_wr && op_r[1] |-> mem_addr == dest_r)
    else $error("extreme search wrote outside destination");
endmodule // word_range_engine_checker
bind word_range_engine word_range_engine_checker chk_i (.mclk, .rst_n, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_readdata, .avs_waitrequest, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata,
  .mem_ack, .irq);

// [word_mem_model.sv]
// word-addressed data memory answering one access at a time with an ack
// assumes the engine holds each request until it sees the ack
`timescale 1ns/1ps
module word_mem_model
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        slow,
  input  wire logic [15:0] mem_addr,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [15:0] mem_wdata,
  output logic      [15:0] mem_rdata,
  output logic             mem_ack
);
  logic [15:0] words [0:63];
  logic [1:0]  wait_r;
  // read data only valid in the ack cycle; it toggles otherwise so stale use shows
  always @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      mem_ack <= 1'b0; wait_r <= 2'h0; mem_rdata <= 16'h5a5a;
    end
    else
    begin
      mem_ack <= 1'b0;
      if ((mem_rd || mem_wr) && !mem_ack && (!slow || wait_r == 2'h3))
      begin
        mem_ack <= 1'b1; wait_r <= 2'h0; mem_rdata <= words[mem_addr[5:0]];
        if (mem_wr) words[mem_addr[5:0]] <= mem_wdata;
      end
      else
      begin
        wait_r <= (mem_rd || mem_wr) ? wait_r + 2'h1 : 2'h0; mem_rdata <= ~mem_rdata;
      end
    end
endmodule // word_mem_model

// [testbench.sv]
// self-checking bench: register tasks on avalon-mm, memory model behind the engine
// assumes status busy drops only after results and flags are written
`timescale 1ns/1ps
`include "range_engine_defines.vh"
module testbench;
  logic        mclk, rst_n, avs_read, avs_write, slow;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, q;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest, mem_rd, mem_wr, mem_ack, irq;
  wire  [15:0] mem_addr, mem_wdata, mem_rdata;
  integer      n_mismatch, n_checks, k;
  word_range_engine uut (.mclk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata, .mem_ack, .irq);
  word_mem_model mdl (.mclk, .rst_n, .slow, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata, .mem_ack);
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task complete_run;
  begin
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
  begin
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask
  // one avalon transfer; request held until waitrequest is sampled low
  task bus(input integer rd, input [3:0] a, input [15:0] d);
    integer i;
  begin
    @(posedge mclk);
    avs_address <= a; avs_read <= (rd != 0); avs_write <= (rd == 0); avs_writedata <= {16'h0000, d};
    i = 0;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0 && i < 200)
    begin
      i = i + 1;
      @(posedge mclk);
    end
    q = avs_readdata;
    avs_read <= 1'b0; avs_write <= 1'b0;
    if (i == 200)
    begin
      n_mismatch = n_mismatch + 1;
      complete_run;
    end
  end
  endtask
  // runs one operation and leaves the final status word in q
  task op(input [1:0] o, input [15:0] first, input [15:0] len, input [15:0] opt, input [15:0] cmp);
  begin
    bus(0, `REG_LEN, len); bus(0, `REG_OPT, opt); bus(0, `REG_FIRST, first); bus(0, `REG_CMPV, cmp);
    bus(0, `REG_CTRL, {8'h01, 6'h00, o});
    k = 0;
    q = 32'h1;
    while (q[0] !== 1'b0 && k < 500)
    begin
      bus(1, `REG_STATUS, 16'h0000);
      k = k + 1;
    end
    if (k == 500)
    begin
      n_mismatch = n_mismatch + 1;
      complete_run;
    end
    // two more edges let the sticky bits and the registered irq catch up with done
    repeat (2) @(posedge mclk);
    $display("op %0d on %h len %h done", o, first, len);
  end
  endtask
  task ext(input [1:0] o, input [15:0] first, input [15:0] len, input [15:0] opt, input [15:0] val,
           input [15:0] idx, input [2:0] flags);
  begin
    op(o, first, len, opt, 16'h0000);
    chk({13'h0000, q[3:1]}, {13'h0000, flags});
    chk(mdl.words[32], val);
    bus(1, `REG_RESULT, 16'h0000);
    chk(q[15:0], val);
    bus(1, `REG_INDEX, 16'h0000);
    chk(q[15:0], idx);
  end
  endtask
  initial
  begin
    rst_n = 1'b0; avs_read = 1'b0; avs_write = 1'b0; avs_address = 4'h0; avs_writedata = 32'h0; slow = 1'b0;
    n_mismatch = 0; n_checks = 0;
    for (k = 0; k < 64; k = k + 1) mdl.words[k] = 16'h0000;
    mdl.words[16] = 16'h8000; mdl.words[17] = 16'h0005; mdl.words[18] = 16'h7fff;
    mdl.words[19] = 16'h0005; mdl.words[20] = 16'h8000; mdl.words[24] = 16'h0000;
    mdl.words[48] = 16'h4142; mdl.words[49] = 16'h4344; mdl.words[50] = 16'h4546; mdl.words[51] = 16'h1234;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    bus(0, `REG_IRQ_MASK, 16'h0003); bus(0, `REG_DEST, 16'h0020);
    op(`OP_SEARCH, 16'h0010, 16'h0005, 16'h8000, 16'h0005);
    chk({14'h0000, q[2:1]}, 16'h0002);
    chk({15'h0, irq}, 16'h0001);
    bus(1, `REG_INDEX, 16'h0000); chk(q[15:0], 16'h0011);
    bus(1, `REG_DATA0, 16'h0000); chk(q[15:0], 16'h0002);
    bus(1, `REG_IRQ_STAT, 16'h0000); chk({14'h0000, q[1:0]}, 16'h0001);
    bus(1, `REG_IRQ_STAT, 16'h0000); chk({14'h0000, q[1:0]}, 16'h0000);
    chk({15'h0, irq}, 16'h0000);
    op(`OP_SEARCH, 16'h0010, 16'h0005, 16'h8000, 16'h1234); chk({14'h0000, q[2:1]}, 16'h0000);
    bus(1, `REG_INDEX, 16'h0000); chk(q[15:0], 16'h0011);
    bus(1, `REG_DATA0, 16'h0000); chk(q[15:0], 16'h0002);
    op(`OP_SEARCH, 16'h0010, 16'h0005, 16'h0000, 16'h7fff); chk({14'h0000, q[2:1]}, 16'h0002);
    bus(1, `REG_INDEX, 16'h0000); chk(q[15:0], 16'h0012);
    bus(1, `REG_DATA0, 16'h0000); chk(q[15:0], 16'h0002);
    ext(`OP_MAX, 16'h0010, 16'h0005, 16'h4000, 16'h8000, 16'h0010, 3'b100);
    ext(`OP_MAX, 16'h0010, 16'h0005, 16'hc000, 16'h7fff, 16'h0012, 3'b000);
    ext(`OP_MIN, 16'h0010, 16'h0005, 16'hc000, 16'h8000, 16'h0010, 3'b100);
    ext(`OP_MIN, 16'h0010, 16'h0005, 16'h4000, 16'h0005, 16'h0011, 3'b000);
    ext(`OP_MIN, 16'h0010, 16'h0005, 16'h8000, 16'h8000, 16'h0011, 3'b100);
    ext(`OP_MAX, 16'h0018, 16'h0001, 16'h4000, 16'h0000, 16'h0018, 3'b010);
    @(posedge mclk);
    slow <= 1'b1;
    op(`OP_SWAP, 16'h0030, 16'h0003, 16'h0000, 16'h0000); chk({13'h0000, q[3:1]}, 16'h0002);
    chk(mdl.words[48], 16'h4241); chk(mdl.words[49], 16'h4443);
    chk(mdl.words[50], 16'h4645); chk(mdl.words[51], 16'h1234);
    bus(0, `REG_IRQ_MASK, 16'h0002); bus(1, `REG_IRQ_STAT, 16'h0000);
    op(`OP_SWAP, 16'h0030, 16'h0000, 16'h0000, 16'h0000); chk({13'h0000, q[3:1]}, 16'h0003);
    chk(mdl.words[48], 16'h4241); chk({15'h0, irq}, 16'h0001);
    bus(1, `REG_IRQ_STAT, 16'h0000); chk({14'h0000, q[1:0]}, 16'h0003);
    op(`OP_MAX, 16'h0010, 16'h0000, 16'h4000, 16'h0000); chk({13'h0000, q[3:1]}, 16'h0003);
    chk(mdl.words[32], 16'h0000);
    bus(1, `REG_INDEX, 16'h0000); chk(q[15:0], 16'h0018);
    bus(0, `REG_IRQ_MASK, 16'h0000); bus(1, `REG_IRQ_STAT, 16'h0000);
    op(`OP_SEARCH, 16'h0010, 16'h0000, 16'h0000, 16'h0005); chk({13'h0000, q[3:1]}, 16'h0003);
    chk({15'h0, irq}, 16'h0000);
    bus(1, 4'hc, 16'h0000);
    chk(q[15:0], 16'h0000);
    complete_run;
  end
endmodule // testbench
